// ### verif/tb_top.sv
`timescale 1ns/10ps
`include "vpd_params.svh"

// Self-checking bench for the fetch and dispatch front end
module tb_top;
   import vpd_pkg::*;

   // One packet as seen at the unit outputs
   typedef struct {
      int                    cyc;
      logic [7:0]            mask;
      logic [`VPD_PKT_W-1:0] word;
      logic [31:0]           mode;
      logic [7:0]            ill;
   } vpd_obs_t;

   logic                  i_core_clk;   // Core clock
   logic                  i_rst_n;      // Reset, active low
   logic                  fetch_req;    // Fetch request
   logic [31:0]           fetch_addr;   // Fetch byte address
   logic                  fetch_valid;  // Packet returned
   logic [`VPD_PKT_W-1:0] fetch_data;   // Packet data
   logic                  wr_valid;     // Write-back seen
   logic                  wr_side;      // Written side
   logic [4:0]            wr_reg;       // Written register
   logic [7:0]            unit_valid;   // Unit strobes
   logic [`VPD_PKT_W-1:0] unit_word;    // Unit words
   logic [31:0]           unit_mode;    // Unit modes
   logic [7:0]            unit_ill;     // Illegal mode flags
   logic                  stall;        // Inserted stall
   logic [3:0]            lat;          // Memory wait setting
   int                    error_cnt;
   int                    comparisons;
   int                    cyc;
   int                    stalls;
   int                    take_cyc[$];
   logic [31:0]           take_addr[$];
   vpd_obs_t              obs[$];

   vpd_dispatch DUT (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .o_fetch_req(fetch_req), .o_fetch_addr(fetch_addr),
      .i_fetch_valid(fetch_valid), .i_fetch_data(fetch_data),
      .i_wr_valid(wr_valid), .i_wr_side(wr_side), .i_wr_reg(wr_reg),
      .o_unit_valid(unit_valid), .o_unit_word(unit_word),
      .o_unit_mode(unit_mode), .o_unit_illegal(unit_ill), .o_stall(stall));

   vpd_prog_mem u_mem (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(fetch_req),
      .i_addr(fetch_addr), .i_lat(lat), .o_valid(fetch_valid), .o_data(fetch_data));

   // 50 ns core clock
   initial begin
      i_core_clk = 1'b0;
      forever #25 i_core_clk = ~i_core_clk;
   end

   // Monitor: values seen before each edge's updates land
   always @(posedge i_core_clk) begin
      cyc++;
      if (i_rst_n === 1'b1) begin
         if (unit_valid !== 8'h00)
            obs.push_back(vpd_obs_t'{cyc, unit_valid, unit_word, unit_mode, unit_ill});
         if (fetch_req === 1'b1 && fetch_valid === 1'b1) begin
            take_cyc.push_back(cyc);
            take_addr.push_back(fetch_addr);
         end
         if (stall === 1'b1)
            stalls++;
      end
   end

   // Word: mode, source reg 5, cross bit, unit, chain bit
   function automatic logic [31:0] wd(input logic [2:0] u, input logic c,
                                      input logic [3:0] m, input logic x);
      return {18'h0, m, 5'h5, x, u, c};
   endfunction

   task automatic chk(input logic [255:0] seen, input logic [255:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   task automatic print_verdict();
      $display("counts: %0d mismatches, %0d comparisons", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Every packet holds eight single-word packets, unit = slot
   task automatic fill();
      for (int p = 0; p < 16; p++)
         for (int w = 0; w < 8; w++)
            u_mem.pkt[p][32*w+:32] = wd(w[2:0], 1'b0, 4'h0, 1'b0);
   endtask

   task automatic restart(input logic [3:0] l);
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      lat     <= l;
      repeat (8) @(posedge i_core_clk);
      obs.delete();
      take_cyc.delete();
      take_addr.delete();
      stalls = 0;
      i_rst_n <= 1'b1;
   endtask

   // Bounded wait for n dispatched packets
   task automatic wait_obs(input int n);
      for (int k = 0; k < 400 && obs.size() < n; k++)
         @(posedge i_core_clk);
      if (obs.size() < n) begin
         error_cnt++;
         $display("mismatch at %0t: packets never came", $time);
         print_verdict();
      end
   endtask

   task automatic t_reset();
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      chk(fetch_req, 1'b1, "reset request");
      chk(fetch_addr, 32'h0000_0000, "reset address");
      chk({unit_valid, stall}, 9'h000, "reset outputs");
      $display("test reset done");
   endtask

   // Mixed chains, one 8-word packet, eight single packets
   task automatic t_split();
      logic [7:0] exp [14] = '{8'h03, 8'h04, 8'h38, 8'h40, 8'h80, 8'hFF, 8'h01,
                               8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
      fill();
      for (int w = 0; w < 8; w++) begin
         u_mem.pkt[0][32*w+:32] = wd(w[2:0], (w == 0 || w == 3 || w == 4), 4'h0, 1'b0);
         u_mem.pkt[1][32*w+:32] = wd(w[2:0], (w != 7), 4'h0, 1'b0);
      end
      restart(4'h1);
      wait_obs(14);
      for (int i = 0; i < 14; i++)
         chk(obs[i].mask, exp[i], "packet mask");
      for (int i = 1; i < 14; i++)
         if (i != 5 && i != 6)
            chk(obs[i].cyc - obs[i-1].cyc, 1, "packet spacing");
      chk(obs[5].word, u_mem.pkt[1], "full packet words");
      chk(take_addr[1], 32'h0000_0020, "second fetch address");
      chk(take_cyc[1] - take_cyc[0] >= 6, 1, "fetch held back");
      $display("test split done");
   endtask

   // Chain open at word 7 carries into a slow next fetch
   task automatic t_span();
      logic [7:0] exp [14] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'hC1,
                               8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
      fill();
      u_mem.pkt[0][223:192] = wd(3'h6, 1'b1, 4'h0, 1'b0);
      u_mem.pkt[0][255:224] = wd(3'h7, 1'b1, 4'h0, 1'b0);
      restart(4'h6);
      wait_obs(14);
      for (int i = 0; i < 14; i++)
         chk(obs[i].mask, exp[i], "span mask");
      chk({obs[6].word[255:192], obs[6].word[31:0]},
          {u_mem.pkt[0][255:192], u_mem.pkt[1][31:0]}, "span words");
      chk(obs[6].cyc - obs[5].cyc >= 7, 1, "span waits for fetch");
      $display("test span done");
   endtask

   // Cross-path read of B5: hazard only for a fresh write of that register
   task automatic t_cross();
      logic       sd [3] = '{1'b1, 1'b0, 1'b1};
      logic [4:0] rg [3] = '{5'h05, 5'h05, 5'h06};
      int         ex [3] = '{1, 0, 0};
      for (int c = 0; c < 3; c++) begin
         fill();
         u_mem.pkt[0][63:32] = wd(3'h1, 1'b0, 4'h0, 1'b1);
         restart(4'h0);
         wr_side  <= sd[c];
         wr_reg   <= rg[c];
         wr_valid <= 1'b1;
         wait_obs(8);
         chk(stalls, ex[c], "stall count");
         chk(obs[1].cyc - obs[0].cyc, 1 + ex[c], "stall gap");
         wr_valid <= 1'b0;
      end
      $display("test cross done");
   endtask

   // Every mode code on every unit, legal and first illegal
   task automatic t_modes();
      fill();
      for (int k = 0; k < 10; k++)
         for (int w = 0; w < 8; w++)
            u_mem.pkt[k][32*w+:32] = wd(w[2:0], (w != 7), k[3:0], 1'b0);
      restart(4'h0);
      wait_obs(10);
      for (int k = 0; k < 10; k++) begin
         chk(obs[k].mask, 8'hFF, "all units");
         chk(obs[k].mode, {8{k[3:0]}}, "unit modes");
         chk(obs[k].ill, {k > 3, k > 3, k > 8, k > 7, k > 7, k > 8, k > 3, k > 3},
             "illegal flags");
      end
      $display("test modes done");
   endtask

   // Main sequence
   initial begin
      i_rst_n     = 1'b0;
      wr_valid    = 1'b0;
      wr_side     = 1'b0;
      wr_reg      = 5'h00;
      lat         = 4'h0;
      error_cnt   = 0;
      comparisons = 0;
      cyc         = 0;
      stalls      = 0;
      repeat (8) @(posedge i_core_clk);
      t_reset();
      t_split();
      t_span();
      t_cross();
      t_modes();
      print_verdict();
   end
endmodule

// ### verif/vpd_prog_mem.sv
`timescale 1ns/10ps
`include "vpd_params.svh"

// Program memory: answers each fetch after a set number of waits
module vpd_prog_mem (
   // Clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst_n,
   // Fetch link
   input  wire logic                  i_req,
   input  wire logic [31:0]           i_addr,
   input  wire logic [3:0]            i_lat,
   output logic                       o_valid,
   output logic [`VPD_PKT_W-1:0]      o_data
);
   logic [`VPD_PKT_W-1:0] pkt [16];  // Packet store, loaded by the bench
   logic [3:0]            cnt_reg;   // Wait cycles spent on this request

   // One-cycle answer; data inverts when idle so stale words never match
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
         o_data  <= '0;
         cnt_reg <= 4'h0;
      end else if (o_valid) begin
         // Released after the take edge
         o_valid <= 1'b0;
         o_data  <= ~o_data;
         cnt_reg <= 4'h0;
      end else if (i_req && cnt_reg >= i_lat) begin
         o_valid <= 1'b1;
         o_data  <= pkt[i_addr[8:5]];
      end else begin
         // Slow answer: count waits while asked
         o_data  <= ~o_data;
         cnt_reg <= i_req ? cnt_reg + 4'h1 : 4'h0;
      end
   end
endmodule

// ### verilog/vpd_dispatch.sv
`timescale 1ns/10ps
`include "vpd_params.svh"

// What this block does
// RULE1: Fetch 256-bit packets of eight words
// RULE2: Low bit one chains next word
// RULE3: Low bit zero closes the packet
// RULE4: At most eight words per packet
// RULE5: Packets may span fetch boundaries
// RULE6: One to eight packets per fetch
// RULE7: One execute packet per clock
// RULE8: No fetch until packet fully dispatched
// RULE9: All addressed units driven together
// RULE10: Multiply units do 16x16, 8x8 products
// RULE11: Multiply extras: 16x32, sums, shifts
// RULE12: ALU lanes: 32, dual 16, quad 8
// RULE13: Loads/stores byte to doubleword sizes
// RULE14: Stall once on fresh cross-path read
// RULE15: Ascending word order, address plus 32
// RULE16: Spanning packet waits for next fetch
module vpd_dispatch #(
   parameter logic [31:0] RESET_ADDR = `VPD_RESET_ADDR  // First fetch address
) (
   // Clock and reset
   input  wire logic                       i_core_clk,
   input  wire logic                       i_rst_n,
   // Program memory
   output logic                            o_fetch_req,
   output logic [31:0]                     o_fetch_addr,
   input  wire logic                       i_fetch_valid,
   input  wire logic [`VPD_PKT_W-1:0]      i_fetch_data,
   // Register write-back seen by dispatch
   input  wire logic                       i_wr_valid,
   input  wire logic                       i_wr_side,
   input  wire logic [4:0]                 i_wr_reg,
   // Functional unit drive
   output logic [`VPD_WORDS-1:0]           o_unit_valid,
   output logic [`VPD_PKT_W-1:0]           o_unit_word,
   output logic [`VPD_WORDS*4-1:0]         o_unit_mode,
   output logic [`VPD_WORDS-1:0]           o_unit_illegal,
   // Status
   output logic                            o_stall
);
   import vpd_pkg::*;

   // Refuse a start address off a packet boundary; the word index assumes alignment
   if (RESET_ADDR[4:0] != 5'h0) begin : g_bad_reset_addr
      $error("fetch address must be packet aligned");
   end

   vpd_state_t             state_reg;              // Sequencer state
   logic [`VPD_WORD_W-1:0] cur_reg [`VPD_WORDS];   // Current fetch packet
   logic [`VPD_WORD_W-1:0] carry_reg [`VPD_WORDS]; // Tail of a spanning packet
   logic [3:0]             carry_cnt_reg;          // Words held in carry
   logic [3:0]             pos_reg;                // Next unread word
   logic                   stalled_reg;            // Stall clock already spent
   logic                   wr_prev_valid_reg;      // Write seen last cycle
   logic                   wr_prev_side_reg;
   logic [4:0]             wr_prev_reg_reg;

   logic [`VPD_PKT_W-1:0]  ep_words;  // Packet being formed
   logic [3:0]             ep_cnt;    // Its length
   logic                   ep_span;   // Runs off the fetch packet
   logic                   ep_haz;    // Fresh cross-path read inside
   logic                   fin;       // Scan closed
   logic [4:0]             idx;       // Index into current packet
   logic [`VPD_WORD_W-1:0] w;         // Word under scan
   logic [3:0]             pos_next;  // Read point after issue
   logic                   issue;     // Packet leaves this cycle
   logic                   stall;     // Inserted stall clock

   vpd_issue_if iss ();

   // Scan words in ascending order, carry first
   always_comb begin
      ep_words = '0;
      ep_cnt   = '0;
      ep_span  = 1'b0;
      ep_haz   = 1'b0;
      fin      = 1'b0;
      idx      = '0;
      w        = '0;
      for (int k = 0; k < `VPD_WORDS; k++) begin
         if (!fin) begin
            idx = 5'({1'b0, pos_reg} + 5'(k) - {1'b0, carry_cnt_reg}); // RULE15
            if (4'(k) < carry_cnt_reg) begin
               w = carry_reg[k];
            end else if (idx > 5'h7) begin
               // Chain still open at the packet end
               ep_span = 1'b1; // RULE5
               fin     = 1'b1;
            end else begin
               w = cur_reg[idx[2:0]];
            end
            if (!fin) begin
               ep_words[k*32 +: 32] = w;
               ep_cnt               = 4'(k + 1);
               // Other-side read of a register written last cycle
               if (w[`VPD_F_CROSS] && wr_prev_valid_reg &&
                   wr_prev_side_reg != w[`VPD_F_SIDE] &&
                   wr_prev_reg_reg == w[`VPD_F_SRC_HI:`VPD_F_SRC_LO]) begin
                  ep_haz = 1'b1; // RULE14
               end
               // Zero closes, one chains on, eight closes anyway
               if (!w[`VPD_F_CHAIN] || k == `VPD_WORDS - 1) begin
                  fin = 1'b1; // RULE2 RULE3 RULE4
               end
            end
         end
      end
   end

   assign pos_next    = pos_reg + ep_cnt - carry_cnt_reg;
   assign stall       = (state_reg == VPD_S_ISSUE) && !ep_span && ep_haz && !stalled_reg;
   assign issue       = (state_reg == VPD_S_ISSUE) && !ep_span && !stall; // RULE7
   assign o_fetch_req = (state_reg == VPD_S_FETCH); // RULE8
   assign o_stall     = stall;

   // Sequencer: fetch waits on memory, issue drains the packet
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= VPD_S_FETCH;
      end else if (state_reg == VPD_S_FETCH) begin
         if (i_fetch_valid) begin
            state_reg <= VPD_S_ISSUE; // RULE16
         end
      end else if (ep_span || (issue && pos_next == 4'h8)) begin
         state_reg <= VPD_S_FETCH; // RULE8 RULE6
      end
   end

   // Fetch address steps one packet per accepted fetch
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fetch_addr <= RESET_ADDR;
      end else if (o_fetch_req && i_fetch_valid) begin
         o_fetch_addr <= o_fetch_addr + `VPD_PKT_BYTES; // RULE15
      end
   end

   // Packet store; word 0 is the lowest address
   for (genvar i = 0; i < `VPD_WORDS; i++) begin : g_word
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            cur_reg[i]   <= '0;
            carry_reg[i] <= '0;
         end else begin
            if (o_fetch_req && i_fetch_valid) begin
               cur_reg[i] <= i_fetch_data[i*32 +: 32]; // RULE1
            end
            if (state_reg == VPD_S_ISSUE && ep_span) begin
               carry_reg[i] <= ep_words[i*32 +: 32]; // RULE5
            end
         end
      end
   end

   // Read point and carry count
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pos_reg       <= '0;
         carry_cnt_reg <= '0;
      end else if (o_fetch_req && i_fetch_valid) begin
         pos_reg <= '0;
      end else if (state_reg == VPD_S_ISSUE && ep_span) begin
         carry_cnt_reg <= ep_cnt;
         pos_reg       <= 4'h8;
      end else if (issue) begin
         carry_cnt_reg <= '0;
         pos_reg       <= pos_next;
      end
   end

   // Stall bookkeeping; the write is remembered for one cycle
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stalled_reg       <= 1'b0;
         wr_prev_valid_reg <= 1'b0;
         wr_prev_side_reg  <= 1'b0;
         wr_prev_reg_reg   <= '0;
      end else begin
         stalled_reg       <= stall; // RULE14
         wr_prev_valid_reg <= i_wr_valid;
         wr_prev_side_reg  <= i_wr_side;
         wr_prev_reg_reg   <= i_wr_reg;
      end
   end

   // Issue register toward the router
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         iss.valid <= 1'b0;
         iss.cnt   <= '0;
         iss.words <= '0;
      end else begin
         iss.valid <= issue;
         iss.cnt   <= issue ? ep_cnt : 4'h0;
         iss.words <= ep_words;
      end
   end

   vpd_unit_router u_router (
      .i_core_clk     (i_core_clk),
      .i_rst_n        (i_rst_n),
      .iss            (iss.dst),
      .o_unit_valid   (o_unit_valid),
      .o_unit_word    (o_unit_word),
      .o_unit_mode    (o_unit_mode),
      .o_unit_illegal (o_unit_illegal)
   );

   // Helper: chain bits of an issued packet
   logic chain_ok;
   always_comb begin
      chain_ok = 1'b1;
      for (int k = 0; k < `VPD_WORDS - 1; k++) begin
         if (4'(k + 1) < iss.cnt && !iss.words[k*32]) chain_ok = 1'b0;
         if (4'(k + 1) == iss.cnt && iss.words[k*32]) chain_ok = 1'b0;
      end
   end

   sequence s_accept;
      o_fetch_req && i_fetch_valid;
   endsequence
   sequence s_loaded;
      state_reg == VPD_S_ISSUE && pos_reg == 4'h0;
   endsequence

   property p_load;
      @(posedge i_core_clk) disable iff (!i_rst_n) s_accept |=> s_loaded;
   endproperty
   a_load: assert property (p_load) else $error("packet not loaded"); // RULE1

   property p_step;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      s_accept |=> o_fetch_addr == $past(o_fetch_addr) + `VPD_PKT_BYTES;
   endproperty
   a_step: assert property (p_step) else $error("fetch address step wrong"); // RULE15

   property p_chain;
      @(posedge i_core_clk) disable iff (!i_rst_n) iss.valid |-> chain_ok;
   endproperty
   a_chain: assert property (p_chain) else $error("chain bits broken"); // RULE2 RULE3

   property p_size;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      iss.valid |-> iss.cnt >= 4'h1 && iss.cnt <= 4'h8;
   endproperty
   a_size: assert property (p_size) else $error("packet size out of range"); // RULE4

   // A new request only once the last packet left or a chain ran off the end
   property p_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(o_fetch_req) |-> $past(ep_span || (issue && pos_next == 4'h8));
   endproperty
   a_hold: assert property (p_hold) else $error("fetch before drain"); // RULE8

   property p_span;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      state_reg == VPD_S_ISSUE && ep_span |=> o_fetch_req && !iss.valid;
   endproperty
   a_span: assert property (p_span) else $error("span did not refetch"); // RULE5 RULE16

   property p_stall;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      stall |=> issue ##1 iss.valid;
   endproperty
   a_stall: assert property (p_stall) else $error("stall longer than one clock"); // RULE14

   property p_rate;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      state_reg == VPD_S_ISSUE && !ep_span && !ep_haz |=>
         iss.valid && iss.cnt == $past(ep_cnt);
   endproperty
   a_rate: assert property (p_rate) else $error("packet not issued"); // RULE7
endmodule

// ### verilog/vpd_issue_if.sv
`timescale 1ns/10ps
`include "vpd_params.svh"

// Carries one execute packet from the sequencer to the unit router
interface vpd_issue_if;
   logic                  valid;  // One packet this cycle
   logic [3:0]            cnt;    // Words in packet, 1..8
   logic [`VPD_PKT_W-1:0] words;  // Slot 0 in low bits

   modport src (output valid, output cnt, output words);
   modport dst (input valid, input cnt, input words);
endinterface

// ### verilog/vpd_params.svh
`ifndef VPD_PARAMS_SVH
`define VPD_PARAMS_SVH

// Fetch packet geometry
`define VPD_WORD_W        32
`define VPD_WORDS         8
`define VPD_PKT_W         256
`define VPD_PKT_BYTES     32'h0000_0020
`define VPD_RESET_ADDR    32'h0000_0000

// Instruction word fields
`define VPD_F_CHAIN       0
`define VPD_F_UNIT_LO     1
`define VPD_F_UNIT_HI     3
`define VPD_F_SIDE        3
`define VPD_F_CROSS       4
`define VPD_F_SRC_LO      5
`define VPD_F_SRC_HI      9
`define VPD_F_MODE_LO     10
`define VPD_F_MODE_HI     13

// Core clock
`define VPD_CLK_PERIOD_NS 50
`define VPD_STALL_CYCLES  1

`endif

// ### verilog/vpd_pkg.sv
package vpd_pkg;
   // Dispatch sequencer states
   typedef enum logic [0:0] {
      VPD_S_FETCH,
      VPD_S_ISSUE
   } vpd_state_t;

   // Unit select encoding, side A then side B
   typedef enum logic [2:0] {
      VPD_U_L1, VPD_U_S1, VPD_U_M1, VPD_U_D1,
      VPD_U_D2, VPD_U_M2, VPD_U_S2, VPD_U_L2
   } vpd_unit_t;

   // Multiply unit operations
   typedef enum logic [3:0] {
      VPD_MUL_DUAL16, VPD_MUL_QUAD8, VPD_MUL_16X32, VPD_MUL_DUAL_ADDSUB,
      VPD_MUL_QUAD_ADD, VPD_MUL_BITCNT, VPD_MUL_ROTATE, VPD_MUL_GFMUL,
      VPD_MUL_VSHIFT
   } vpd_mul_op_t;

   // Shift and logic unit lane modes
   typedef enum logic [3:0] {
      VPD_ALU_SINGLE32, VPD_ALU_DUAL16, VPD_ALU_QUAD8, VPD_ALU_BRANCH
   } vpd_alu_op_t;

   // Load/store access sizes, bit 2 selects store
   typedef enum logic [3:0] {
      VPD_LS_LD_BYTE, VPD_LS_LD_HALF, VPD_LS_LD_WORD, VPD_LS_LD_DWORD,
      VPD_LS_ST_BYTE, VPD_LS_ST_HALF, VPD_LS_ST_WORD, VPD_LS_ST_DWORD
   } vpd_ls_op_t;
endpackage

// ### verilog/vpd_unit_router.sv
`timescale 1ns/10ps
`include "vpd_params.svh"

// Steers each slot of an execute packet onto its functional unit
module vpd_unit_router (
   // Clock and reset
   input  wire logic                           i_core_clk,
   input  wire logic                           i_rst_n,
   // Packet in
   vpd_issue_if.dst                            iss,
   // Unit drive
   output logic [`VPD_WORDS-1:0]               o_unit_valid,
   output logic [`VPD_PKT_W-1:0]               o_unit_word,
   output logic [`VPD_WORDS*4-1:0]             o_unit_mode,
   output logic [`VPD_WORDS-1:0]               o_unit_illegal
);
   import vpd_pkg::*;

   // One lane per unit, all driven on the same edge
   for (genvar u = 0; u < `VPD_WORDS; u++) begin : g_unit
      logic                   hit;   // Some slot targets this unit
      logic [`VPD_WORD_W-1:0] word;  // Lowest such slot
      logic                   bad;   // Mode not served by this unit

      // Lowest slot wins if code doubles up on a unit
      always_comb begin
         hit  = 1'b0;
         word = '0;
         for (int k = `VPD_WORDS - 1; k >= 0; k--) begin
            if (4'(k) < iss.cnt &&
                iss.words[k*32+`VPD_F_UNIT_LO +: 3] == 3'(u)) begin
               hit  = 1'b1;
               word = iss.words[k*32 +: 32];
            end
         end
      end

      // Mode range per unit class
      always_comb begin
         bad = 1'b0;
         if (u == VPD_U_M1 || u == VPD_U_M2) begin
            bad = word[`VPD_F_MODE_HI:`VPD_F_MODE_LO] > VPD_MUL_VSHIFT; // RULE10 RULE11
         end else if (u == VPD_U_D1 || u == VPD_U_D2) begin
            bad = word[`VPD_F_MODE_HI:`VPD_F_MODE_LO] > VPD_LS_ST_DWORD; // RULE13
         end else begin
            bad = word[`VPD_F_MODE_HI:`VPD_F_MODE_LO] > VPD_ALU_BRANCH; // RULE12
         end
      end

      // Registered unit drive
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            o_unit_valid[u]         <= 1'b0;
            o_unit_word[u*32 +: 32] <= '0;
            o_unit_mode[u*4 +: 4]   <= '0;
            o_unit_illegal[u]       <= 1'b0;
         end else begin
            o_unit_valid[u]         <= iss.valid & hit; // RULE9
            o_unit_word[u*32 +: 32] <= word;
            o_unit_mode[u*4 +: 4]   <= word[`VPD_F_MODE_HI:`VPD_F_MODE_LO];
            o_unit_illegal[u]       <= iss.valid & hit & bad;
         end
      end
   end

   // A packet always reaches at least one unit on the next edge
   property p_route;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      iss.valid |=> (o_unit_valid != '0);
   endproperty
   a_route: assert property (p_route) else $error("packet reached no unit"); // RULE9
endmodule
